// ===== hdl/fsrr_top.sv
// Host register set of the floppy controller: data port, disk-input status,
// rate control and result status bytes. Assumes the command engine supplies
// event pulses on this clock and that pins arrive asynchronously.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module fsrr_top import fsrr_pkg::*; (
    input wire logic clk, // 250 MHz system clock
    input wire logic arst_n, // async reset, active low
    input wire logic [2:0] addr, // register index
    input wire logic [7:0] wdata, // write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    output logic [7:0] rdata, // read data, cycle after strobe
    output logic [7:0] rdata_oe_n, // per-bit drive enable, low drives
    input wire logic [1:0] compat_mode, // layout A, B or C
    input wire logic soft_reset, // software reset pulse
    input wire logic tape_unit_config, // tape rate bit
    input wire logic disk_changed_input, // drive pin
    input wire logic write_protect_in, // drive pin
    input wire logic head_select_output, // head select level
    input wire logic [1:0] drive_number, // selected logical drive
    input wire logic svc_req, // service request pulse
    input wire logic dma_ack, // DMA acknowledge pulse
    input wire logic [7:0] exec_rdata, // execution-phase read byte
    input wire logic cmd_start, // command start pulse
    input wire logic write_cmd_issue, // write or format issued
    input wire logic exec_end, // execution end pulse
    input wire logic [1:0] exec_ic, // termination code
    input wire logic seek_done, // seek or recalibrate done
    input wire logic recal_no_trk0, // recalibrate failed
    input wire logic last_byte_no_tc, // end of track event
    input wire logic crc_addr, // address-field CRC error
    input wire logic crc_data, // data-field CRC error
    input wire logic sector_not_found, // sector absent, marks seen
    input wire logic read_id_fail, // no clean ID field
    input wire logic track_start_missing, // read-track start lost
    input wire logic addr_mark_missing, // no address mark
    input wire logic data_mark_missing, // no data mark
    input wire logic result_start, // result phase start pulse
    input wire logic [1:0] result_len, // result bytes, 1 to 3
    output logic drq, // DMA service request
    output logic floppy_interrupt_line, // interrupt service request
    output logic [1:0] data_rate_code, // effective rate code
    output logic no_precomp, // no-precompensation flag
    output logic result_phase // result bytes pending
);
    // --------------------------------------------------------------
    // Reset release
    // --------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // --------------------------------------------------------------
    // Pins and mode
    // --------------------------------------------------------------
    logic [1:0] pin_s;
    logic dc_s;
    logic wp_s;
    fsrr_mode_t mode;

    fsrr_sync #(.WIDTH(2)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din({write_protect_in, disk_changed_input}),
        .dout(pin_s)
    );
    assign dc_s = pin_s[0];
    assign wp_s = pin_s[1];

    // Spare code falls back to the plainest layout
    always_comb begin
        case (compat_mode)
            MODE_B: mode = MODE_B;
            MODE_C: mode = MODE_C;
            default: mode = MODE_A;
        endcase
    end

    // --------------------------------------------------------------
    // Rate, precompensation and control registers
    // --------------------------------------------------------------
    logic wr_rc;
    logic wr_rs;
    logic [7:0] oc_r;
    logic [7:0] cfg_r;
    logic dma_en;
    logic [3:0] thr_eff;
    logic high_density;

    assign wr_rc = wr_en && (addr == ADDR_DISK_INPUT);
    assign wr_rs = wr_en && (addr == ADDR_RATE_SELECT);

    // Soft reset deliberately absent: only hardware reset reloads the rate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_rate_code <= RATE_RESET;
        end else if (wr_rc || wr_rs) begin
            data_rate_code <= wdata[1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            no_precomp <= 1'b0;
        end else if (wr_rc && mode == MODE_C) begin
            no_precomp <= wdata[NO_PRECOMP_BIT_POS];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oc_r <= OC_RESET;
            cfg_r <= CFG_RESET;
        end else if (wr_en && addr == ADDR_OUTPUT_CTRL) begin
            oc_r <= wdata;
        end else if (wr_en && addr == ADDR_CONFIG) begin
            cfg_r <= wdata;
        end
    end

    assign dma_en = oc_r[DMA_EN_POS];
    assign thr_eff = cfg_r[FIFO_EN_POS] ? cfg_r[3:0] : 4'h0;
    assign high_density = (data_rate_code == RATE_300K) || (data_rate_code == RATE_250K);

    // --------------------------------------------------------------
    // Service request and deadline
    // --------------------------------------------------------------
    logic [16:0] svc_cnt_r;
    logic svc_pend;
    logic svc_ack;
    logic data_acc;
    logic overrun_ev;
    logic res_active_r;

    assign data_acc = (rd_en || wr_en) && (addr == ADDR_DATA_PORT) && !res_active_r;
    assign svc_ack = dma_ack || data_acc;
    assign svc_pend = drq || floppy_interrupt_line;
    // Fires once, on the last cycle of the allowed window
    assign overrun_ev = svc_pend && !svc_ack && (svc_cnt_r == 17'd1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drq <= 1'b0;
            floppy_interrupt_line <= 1'b0;
        end else if (soft_reset || svc_ack) begin
            drq <= 1'b0;
            floppy_interrupt_line <= 1'b0;
        end else if (svc_req) begin
            drq <= dma_en;
            floppy_interrupt_line <= !dma_en;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            svc_cnt_r <= 17'd0;
        end else if (soft_reset || svc_ack) begin
            svc_cnt_r <= 17'd0;
        end else if (svc_req) begin
            svc_cnt_r <= svc_cycles(data_rate_code, tape_unit_config, thr_eff);
        end else if (svc_pend && svc_cnt_r != 17'd0) begin
            svc_cnt_r <= svc_cnt_r - 17'd1;
        end
    end

    // --------------------------------------------------------------
    // Result status bytes
    // --------------------------------------------------------------
    logic [7:0] st0, st1, st2;
    logic [1:0] res_idx_r;
    logic [1:0] res_last_r;
    logic [7:0] res_byte;
    logic res_rd;

    fsrr_status u_status (
        .clk(clk),
        .rst_n(rst_n),
        .clr(cmd_start || soft_reset),
        .exec_end(exec_end),
        .exec_ic(exec_ic),
        .head_sel(head_select_output),
        .drive_num(drive_number),
        .seek_done(seek_done),
        .recal_no_trk0(recal_no_trk0),
        .last_byte_no_tc(last_byte_no_tc),
        .crc_addr(crc_addr),
        .crc_data(crc_data),
        .overrun_ev(overrun_ev),
        .no_data_ev(sector_not_found || read_id_fail || track_start_missing),
        .write_cmd(write_cmd_issue),
        .write_prot(wp_s),
        .addr_mark_miss(addr_mark_missing),
        .data_mark_miss(data_mark_missing),
        .st0(st0),
        .st1(st1),
        .st2(st2)
    );

    assign res_rd = rd_en && (addr == ADDR_DATA_PORT) && res_active_r;

    always_comb begin
        case (res_idx_r)
            2'h0: res_byte = st0;
            2'h1: res_byte = st1;
            default: res_byte = st2;
        endcase
    end

    // A zero length is treated as one byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_active_r <= 1'b0;
            res_idx_r <= 2'h0;
            res_last_r <= 2'h0;
        end else if (soft_reset) begin
            res_active_r <= 1'b0;
        end else if (result_start) begin
            res_active_r <= 1'b1;
            res_idx_r <= 2'h0;
            res_last_r <= (result_len == 2'h0) ? 2'h0 : result_len - 2'h1;
        end else if (res_rd) begin
            res_idx_r <= res_idx_r + 2'h1;
            if (res_idx_r == res_last_r) res_active_r <= 1'b0;
        end
    end
    assign result_phase = res_active_r;

    // --------------------------------------------------------------
    // Read path
    // --------------------------------------------------------------
    logic [7:0] dir_value;

    // Disk-input layout holds no flops, so software reset cannot touch it
    always_comb begin
        case (mode)
            MODE_B: dir_value = {dc_s, 4'hf, data_rate_code, high_density};
            MODE_C: dir_value = {!dc_s, 3'h0, dma_en, no_precomp, data_rate_code};
            default: dir_value = {dc_s, 7'h00};
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
            rdata_oe_n <= 8'hff;
        end else if (rd_en) begin
            rdata_oe_n <= 8'h00;
            case (addr)
                ADDR_DATA_PORT: rdata <= res_active_r ? res_byte : exec_rdata;
                ADDR_DISK_INPUT: begin
                    rdata <= dir_value;
                    if (mode == MODE_A) rdata_oe_n <= DIR_A_OE_N;
                end
                ADDR_OUTPUT_CTRL: rdata <= oc_r;
                ADDR_CONFIG: rdata <= cfg_r;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
            rdata_oe_n <= 8'hff;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    req_route_a: assert property (@(posedge clk) disable iff (!rst_n)
        (svc_req && !svc_ack && !soft_reset) |=> (drq == $past(dma_en))
            && (floppy_interrupt_line == !$past(dma_en)))
        else $error("service request on wrong line");
    rate_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_rc || wr_rs) |=> data_rate_code == $past(wdata[1:0]))
        else $error("rate code did not follow last write");
    rate_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (soft_reset && !wr_rc && !wr_rs) |=> $stable(data_rate_code))
        else $error("soft reset changed rate");
    dir_mode_a_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_en && addr == ADDR_DISK_INPUT && mode == MODE_A)
            |=> rdata_oe_n == 8'h7f && rdata[7] == $past(dc_s))
        else $error("mode A drove low bits");
    dir_mode_b_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_en && addr == ADDR_DISK_INPUT && mode == MODE_B)
            |=> rdata[6:3] == 4'hf && rdata[0] == ($past(data_rate_code) inside {2'h1, 2'h2}))
        else $error("mode B layout wrong");
    dir_mode_c_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_en && addr == ADDR_DISK_INPUT && mode == MODE_C)
            |=> rdata[7] == !$past(dc_s) && rdata[6:4] == 3'h0 && rdata[3] == $past(dma_en))
        else $error("mode C layout wrong");
    deadline_a: assert property (@(posedge clk) disable iff (!rst_n)
        (svc_req && !svc_ack && !soft_reset && thr_eff == 4'h0 && data_rate_code == RATE_1M
            && !tape_unit_config) ##1 (svc_pend && !svc_ack && !soft_reset)[*8]
            |-> svc_cnt_r == 17'd1817)
        else $error("deadline count wrong");
    overrun_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        overrun_ev |=> st1[4])
        else $error("overrun not flagged");
    result_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        (res_rd && res_idx_r == 2'h0) |=> rdata == $past(st0))
        else $error("first result byte not status 0");
    thr_used_a: assert property (@(posedge clk) disable iff (!rst_n)
        (svc_req && !svc_ack && !soft_reset && cfg_r[FIFO_EN_POS] && cfg_r[3:0] == 4'h1
            && data_rate_code == RATE_1M && !tape_unit_config) |=> svc_cnt_r == 17'd3824)
        else $error("threshold not used in deadline");
    tape_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (svc_req && !svc_ack && !soft_reset && thr_eff == 4'h0 && data_rate_code == RATE_1M
            && tape_unit_config) |=> svc_cnt_r == 17'd824)
        else $error("tape rate deadline wrong");
    precomp_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (soft_reset && !wr_rc) |=> $stable(no_precomp))
        else $error("soft reset changed no-precomp");
endmodule // fsrr_top

// ===== common/fsrr_pkg.sv
// Constants, types and helpers for the floppy status and rate register block.
// Assumes one 250 MHz clock and a plain strobe register port.
// Operation
// - Disabled buffer means threshold zero
// - Request on DRQ or interrupt by mode
// - Mode A: only bit 7 driven
// - Disk-input register ignores software reset
// - Mode B: changed, ones, rate bits
// - Mode B bit 0 high for slow rates
// - Mode C: changed inverted, bits 6-4 zero
// - Mode C: DMA enable, no-precomp, rate bits
// - Rate control write-only, hardware reset 250k
// - Latest rate write of either register wins
// - No-precomp bit kept, reserved bits written zero
// - Rate code table, tape bit selects 2M
// - Status bytes only through data port
// - Status 0 interrupt code encoding
// - Seek end, equipment check, bit 3 zero
// - Head and drive sampled at execution end
// - End of track without terminal count
// - CRC flag with data-field companion bit
// - Missed deadline sets overrun flag
// - No data for three causes
// - Not writable on protected write
// - Missing address or data mark
package fsrr_pkg;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_NS = 4;
    localparam int DRP_2M_NS = 500;
    localparam int DRP_1M_NS = 1000;
    localparam int DRP_500K_NS = 2000;
    localparam int DRP_300K_NS = 3333;
    localparam int DRP_250K_NS = 4000;
    localparam int ICP_NS = 42;
    localparam int ICP_CYC = (ICP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SVC_MULT = 8;
    localparam int SVC_OVERHEAD = 16;
    // --------------------------------------------------------------
    // Register map and fields
    // --------------------------------------------------------------
    localparam logic [2:0] ADDR_DATA_PORT = 3'h0;
    localparam logic [2:0] ADDR_DISK_INPUT = 3'h1;
    localparam logic [2:0] ADDR_RATE_SELECT = 3'h2;
    localparam logic [2:0] ADDR_OUTPUT_CTRL = 3'h3;
    localparam logic [2:0] ADDR_CONFIG = 3'h4;
    localparam int NO_PRECOMP_BIT_POS = 2;
    localparam int DMA_EN_POS = 3;
    localparam int FIFO_EN_POS = 4;
    localparam logic [1:0] RATE_RESET = 2'h2;
    localparam logic [7:0] OC_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] DIR_A_OE_N = 8'h7f;
    localparam logic [1:0] RATE_500K = 2'h0;
    localparam logic [1:0] RATE_300K = 2'h1;
    localparam logic [1:0] RATE_250K = 2'h2;
    localparam logic [1:0] RATE_1M = 2'h3;
    typedef enum logic [1:0] {MODE_A = 2'b00, MODE_B = 2'b01, MODE_C = 2'b10} fsrr_mode_t;

    // Deadline in clocks: (thr+1)*8*period - 16*internal period
    function automatic logic [16:0] svc_cycles(input logic [1:0] rate, input logic tape,
                                                input logic [3:0] thr);
        logic [16:0] drp;
        drp = 17'(DRP_250K_NS / CLK_NS);
        case (rate)
            RATE_1M: drp = tape ? 17'(DRP_2M_NS / CLK_NS) : 17'(DRP_1M_NS / CLK_NS);
            RATE_500K: drp = 17'(DRP_500K_NS / CLK_NS);
            RATE_300K: drp = 17'(DRP_300K_NS / CLK_NS);
            default: drp = 17'(DRP_250K_NS / CLK_NS);
        endcase
        return 17'((17'(thr) + 17'd1) * 17'(SVC_MULT) * drp) - 17'(SVC_OVERHEAD * ICP_CYC);
    endfunction
endpackage

// ===== hdl/fsrr_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pins and a synchronous-release reset.
`timescale 1ns/1ps
module fsrr_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic [WIDTH-1:0] din, // raw pins
    output logic [WIDTH-1:0] dout // filtered levels
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            dout <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Only accept a level once two late stages agree
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_r[i] == s3_r[i]) dout[i] <= s3_r[i];
            end
        end
    end
endmodule // fsrr_sync

// ===== hdl/fsrr_status.sv
// Result-phase status byte builder: sticky flags and sampled fields.
// Assumes single-cycle event pulses from the command engine.
`timescale 1ns/1ps
module fsrr_status import fsrr_pkg::*; (
    input wire logic clk, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic clr, // new command or soft reset
    input wire logic exec_end, // end of execution pulse
    input wire logic [1:0] exec_ic, // termination code
    input wire logic head_sel, // head select output level
    input wire logic [1:0] drive_num, // logical drive
    input wire logic seek_done, // seek or recalibrate done
    input wire logic recal_no_trk0, // track zero never seen
    input wire logic last_byte_no_tc, // end of track reached
    input wire logic crc_addr, // address-field CRC error
    input wire logic crc_data, // data-field CRC error
    input wire logic overrun_ev, // deadline missed
    input wire logic no_data_ev, // any no-data cause
    input wire logic write_cmd, // write or format issued
    input wire logic write_prot, // synced protect level
    input wire logic addr_mark_miss, // no address mark
    input wire logic data_mark_miss, // no data mark
    output logic [7:0] st0, // status byte 0
    output logic [7:0] st1, // status byte 1
    output logic [7:0] st2 // status byte 2, bits 5 and 0
);
    logic [1:0] ic_r;
    logic hds_r;
    logic [1:0] drv_r;
    logic se_r, ec_r, et_r, ce_r, cd_r, or_r, nd_r, nw_r, ma_r, md_r;

    // Set wins over a clear in the same cycle
    function automatic logic sticky(input logic q, input logic set, input logic c);
        return set || (q && !c);
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ic_r <= 2'h0;
            hds_r <= 1'b0;
            drv_r <= 2'h0;
        end else if (exec_end) begin
            ic_r <= exec_ic;
            hds_r <= head_sel;
            drv_r <= drive_num;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {se_r, ec_r, et_r, ce_r, cd_r, or_r, nd_r, nw_r, ma_r, md_r} <= 10'h000;
        end else begin
            se_r <= sticky(se_r, seek_done, clr);
            ec_r <= sticky(ec_r, recal_no_trk0, clr);
            et_r <= sticky(et_r, last_byte_no_tc, clr);
            ce_r <= sticky(ce_r, crc_addr || crc_data, clr);
            cd_r <= sticky(cd_r, crc_data, clr);
            or_r <= sticky(or_r, overrun_ev, clr);
            nd_r <= sticky(nd_r, no_data_ev, clr);
            nw_r <= sticky(nw_r, write_cmd && write_prot, clr);
            ma_r <= sticky(ma_r, addr_mark_miss || data_mark_miss, clr);
            md_r <= sticky(md_r, data_mark_miss, clr);
        end
    end

    assign st0 = {ic_r, se_r, ec_r, 1'b0, hds_r, drv_r};
    assign st1 = {et_r, 1'b0, ce_r, or_r, 1'b0, nd_r, nw_r, ma_r};
    assign st2 = {2'b00, cd_r, 4'h0, md_r};

    crc_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
        crc_data |=> st1[5] && st2[5]) else $error("data CRC not flagged twice");
    not_writable_a: assert property (@(posedge clk) disable iff (!rst_n)
        (write_cmd && !write_prot && !clr && !st1[1]) |=> !st1[1])
        else $error("not-writable set without protect");
endmodule // fsrr_status

// ===== verification/fsrr_host_model.sv
// Host side model: answers each service request with a DMA acknowledge.
// Assumes request levels from the block and an answer delay set by the bench.
`timescale 1ns/1ps
module fsrr_host_model (
    input wire logic clk, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic drq, // DMA request
    input wire logic irq, // interrupt request
    input wire logic [15:0] delay, // answer delay in cycles
    output logic dma_ack // acknowledge pulse
);
    initial dma_ack = 1'b0;
    // A long delay makes the host miss the deadline on purpose
    always begin
        @(posedge clk);
        if (rst_n && (drq || irq)) begin
            repeat (delay) @(posedge clk);
            dma_ack <= 1'b1;
            @(posedge clk);
            dma_ack <= 1'b0;
            @(posedge clk);
        end
    end
endmodule // fsrr_host_model

// ===== verification/tb_fsrr_top.sv
// Self-checking bench for the floppy status and rate register block.
// Assumes the host model is compiled before this file.
`timescale 1ns/1ps
module tb_fsrr_top import fsrr_pkg::*; ;
    logic clk = 0, arst_n = 0, wr_en = 0, rd_en = 0, dc = 0, wp = 0, hs = 0, tape = 0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, xrd = 8'h00, rdata, oe_n, v, o;
    logic [1:0] mode = 2'h0, ic = 2'h0, drv = 2'h0, len = 2'h0, rate;
    logic [15:0] ev = 16'h0000, dly = 16'h0000;
    logic drq, irq, ack, np, rph, de, npm;
    logic [31:0] r = 32'ha1f9;
    int err_total = 0, n_checks = 0, nsv;
    always #2 clk = ~clk;
    fsrr_top u_fsrr_top (.clk, .arst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .rdata_oe_n(oe_n), .compat_mode(mode), .soft_reset(ev[15]), .tape_unit_config(tape),
        .disk_changed_input(dc), .write_protect_in(wp), .head_select_output(hs),
        .drive_number(drv), .svc_req(ev[13]), .dma_ack(ack), .exec_rdata(xrd),
        .cmd_start(ev[0]), .write_cmd_issue(ev[1]), .exec_end(ev[2]), .exec_ic(ic),
        .seek_done(ev[3]), .recal_no_trk0(ev[4]), .last_byte_no_tc(ev[5]), .crc_addr(ev[6]),
        .crc_data(ev[7]), .sector_not_found(ev[8]), .read_id_fail(ev[9]),
        .track_start_missing(ev[10]), .addr_mark_missing(ev[11]), .data_mark_missing(ev[12]),
        .result_start(ev[14]), .result_len(len), .drq, .floppy_interrupt_line(irq),
        .data_rate_code(rate), .no_precomp(np), .result_phase(rph));
    fsrr_host_model u_fsrr_host_model (.clk, .rst_n(arst_n), .drq, .irq, .delay(dly),
        .dma_ack(ack));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] dir_exp(input logic [1:0] m, input logic d,
        input logic [1:0] rt, input logic e, input logic p);
        if (m == 2'h1) return {d, 4'hf, rt, rt == RATE_300K || rt == RATE_250K};
        if (m == 2'h2) return {~d, 3'h0, e, p, rt};
        return {d, 7'h00};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        // Let the write land before callers look at outputs
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        v = rdata;
        o = oe_n;
    endtask
    task automatic p(input logic [15:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 16'h0000;
    endtask
    task automatic svc(input logic [7:0] oc, input logic [15:0] d, input logic [7:0] e);
        wr(ADDR_OUTPUT_CTRL, oc);
        p(16'h0001);
        dly <= d;
        p(16'h2000);
        #1;
        chk("drq", {7'h0, oc[DMA_EN_POS]}, {7'h0, drq});
        chk("irq", {7'h0, ~oc[DMA_EN_POS]}, {7'h0, irq});
        for (int i = 0; i < 4000 && (drq || irq); i++) @(posedge clk);
        len <= 2'h2;
        p(16'h4000);
        rd(ADDR_DATA_PORT);
        rd(ADDR_DATA_PORT);
        chk("status1", e, v);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #300000;
        err_total++;
        end_sim();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        npm = 1'b0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk("rate", {6'h0, RATE_RESET}, {6'h0, rate});
        wr(ADDR_CONFIG, 8'h0f);
        for (int m = 0; m < 3; m++) begin
            r = lfsr(r);
            mode <= m[1:0];
            dc <= r[0];
            de = r[1];
            wr(ADDR_OUTPUT_CTRL, {4'h0, de, 3'h0});
            repeat (8) @(posedge clk);
            for (int k = 0; k < 4; k++) begin
                r = lfsr(r);
                if (m == 2 && !k[0]) npm = r[2];
                wr(k[0] ? ADDR_RATE_SELECT : ADDR_DISK_INPUT, {5'h0, r[2], k[1:0]});
                chk("rate", {6'h0, k[1:0]}, {6'h0, rate});
                rd(ADDR_DISK_INPUT);
                chk("disk_input", dir_exp(mode, dc, k[1:0], de, npm), v);
                chk("bit_enable", mode == 2'h0 ? DIR_A_OE_N : 8'h00, o);
            end
        end
        p(16'h8000);
        rd(ADDR_DISK_INPUT);
        chk("disk_input", dir_exp(2'h2, dc, RATE_1M, de, npm), v);
        chk("no_precomp", {7'h0, npm}, {7'h0, np});
        xrd <= r[15:8];
        rd(ADDR_DATA_PORT);
        chk("data_port", r[15:8], v);
        rd(3'h5);
        chk("unmapped", 8'h00, v);
        nsv = SVC_MULT * (DRP_1M_NS / CLK_NS) - SVC_OVERHEAD * ICP_CYC;
        svc(8'h08, 16'(nsv - 12), 8'h00);
        svc(8'h00, 16'(nsv - 12), 8'h00);
        for (int t = 0; t < 4; t++) begin
            r = lfsr(r);
            wp <= r[0];
            hs <= r[1];
            drv <= r[3:2];
            ic <= t[1:0];
            p(16'h0001);
            repeat (8) @(posedge clk);
            p({3'h0, r[17:8], 1'b0, r[6], 1'b0});
            p(16'h0004);
            len <= 2'h3;
            p(16'h4000);
            rd(ADDR_DATA_PORT);
            chk("status0", {t[1:0], r[8], r[9], 1'b0, r[1], r[3:2]}, v);
            chk("result_phase", 8'h01, {7'h0, rph});
            rd(ADDR_DATA_PORT);
            chk("status1", {r[10], 1'b0, r[11] | r[12], 2'h0, |r[15:13], r[6] & r[0],
                r[16] | r[17]}, v);
            rd(ADDR_DATA_PORT);
            chk("status2", {2'h0, r[12], 4'h0, r[17]}, v);
            chk("result_phase", 8'h00, {7'h0, rph});
        end
        svc(8'h08, 16'(nsv + 12), 8'h10);
        wr(ADDR_CONFIG, 8'h11);
        svc(8'h08, 16'(nsv + 12), 8'h00);
        wr(ADDR_CONFIG, 8'h0f);
        tape <= 1'b1;
        nsv = SVC_MULT * (DRP_2M_NS / CLK_NS) - SVC_OVERHEAD * ICP_CYC;
        svc(8'h08, 16'(nsv + 12), 8'h10);
        end_sim();
    end
endmodule // tb_fsrr_top
